// ### core/saip_pkg.sv
// Function
// - Control register holds format, word, slot group
// - I2S: frame sync low left, high right
// - Bit clock 32/64 fs, TDM 128/256 fs
// - I2S: first bit one period after edge
// - Two's complement, MSB first, rising-edge capture
// - Justified formats: sync high left, low right
// - Left-justified: MSB with the sync change
// - Left-justified words 16/24, zeros follow
// - Right-justified: LSB just before sync change
// - Right-justified: leading positions count as zeros
// - TDM entered automatically, 4 or 8 slots
// - TDM words 16/24/32, ratio from slot size
// - Tied clocks: sync at least two periods
// - TDM uses first data input only
// - Four-channel map: group bit 5, swap bit 3
// - Paired outputs: odd/even slot, same group, swap
// - Master clock 128, 256 or 512 fs
// - Frame rate 44.1, 48 or 96 kHz
// - Audio clocks at most 25 MHz
// - Master clock phase free, duty per ratio
// - Clock fault forces Hi-Z, auto resume
package saip_pkg;

    // Device control register
    localparam logic [7:0] SAIP_CTRL_ADDR = 8'h03;
    localparam logic [7:0] SAIP_CTRL_RESET = 8'h04;
    localparam logic [7:0] SAIP_CTRL_MASK = 8'hEE;
    localparam int SAIP_CTRL_WORD_LSB = 6;
    localparam int SAIP_CTRL_GROUP_BIT = 5;
    localparam int SAIP_CTRL_SWAP_BIT = 3;
    localparam int SAIP_CTRL_FMT_LSB = 1;

    typedef enum logic [1:0] {
        SAIP_FMT_LJ = 2'b00,
        SAIP_FMT_RJ = 2'b01,
        SAIP_FMT_I2S = 2'b10,
        SAIP_FMT_I2S_ALT = 2'b11
    } saip_fmt_t;

    typedef enum logic [1:0] {
        SAIP_WORD_24 = 2'b00,
        SAIP_WORD_16 = 2'b01,
        SAIP_WORD_32 = 2'b10,
        SAIP_WORD_RSV = 2'b11
    } saip_word_t;

    // Bit clocks per frame and master clocks per frame
    localparam logic [9:0] SAIP_BCLK_32 = 10'h020;
    localparam logic [9:0] SAIP_BCLK_64 = 10'h040;
    localparam logic [9:0] SAIP_BCLK_128 = 10'h080;
    localparam logic [9:0] SAIP_BCLK_256 = 10'h100;
    localparam logic [9:0] SAIP_MCLK_128 = 10'h080;
    localparam logic [9:0] SAIP_MCLK_256 = 10'h100;
    localparam logic [9:0] SAIP_MCLK_512 = 10'h200;
    localparam logic [9:0] SAIP_FRAME_MAX = 10'h200;
    localparam logic [9:0] SAIP_TDM_SYNC_BITS = 10'h002;

    // Synchroniser lanes
    localparam int SAIP_SY_MCLK = 0;
    localparam int SAIP_SY_BCLK = 1;
    localparam int SAIP_SY_FRAME_SYNC = 2;
    localparam int SAIP_SY_DIN1 = 3;
    localparam int SAIP_SY_DIN2 = 4;

    // Timing
    localparam int SAIP_CORE_MHZ = 200;
    localparam int SAIP_AUDIO_CLK_MAX_MHZ = 25;
    localparam int SAIP_MCLK_HALF_MIN = (SAIP_CORE_MHZ + 2 * SAIP_AUDIO_CLK_MAX_MHZ - 1) / (2 * SAIP_AUDIO_CLK_MAX_MHZ);
    localparam int SAIP_HALT_CYCLES = 1024;

    // Host APB registers
    localparam logic [11:0] SAIP_H_CTRL = 12'h000;
    localparam logic [11:0] SAIP_H_STATUS = 12'h004;
    localparam logic [6:0] SAIP_H_DATA_PAGE = 7'h01;
    localparam logic [31:0] SAIP_H_CTRL_RESET = 32'h0000_0004;
    localparam int SAIP_H_EN_BIT = 0;
    localparam int SAIP_H_FMT_LSB = 1;
    localparam int SAIP_H_WORD_LSB = 3;
    localparam int SAIP_H_TDM_BIT = 5;
    localparam int SAIP_H_FSEL_LSB = 6;
    localparam int SAIP_H_RUN_BIT = 16;

    function automatic logic [5:0] saip_word_bits(input logic [1:0] sel);
        case (sel)
            SAIP_WORD_16: return 6'h10;
            SAIP_WORD_32: return 6'h20;
            default: return 6'h18;
        endcase
    endfunction

endpackage : saip_pkg

// ### core/saip_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface saip_link_if;
    logic master_clk;
    logic bit_clk;
    logic frame_sync;
    logic serial_data_in_first;
    logic serial_data_in_second;

    modport host (
        output master_clk,
        output bit_clk,
        output frame_sync,
        output serial_data_in_first,
        output serial_data_in_second
    );

    modport device (
        input master_clk,
        input bit_clk,
        input frame_sync,
        input serial_data_in_first,
        input serial_data_in_second
    );
endinterface : saip_link_if
`default_nettype wire

// ### core/saip_device.sv
`timescale 1ns/1ps
`default_nettype none
module saip_device #(
    parameter int HALT_CYCLES = saip_pkg::SAIP_HALT_CYCLES
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // Serial audio link
    saip_link_if.device LINK,
    // Control register port
    input wire logic REG_WE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Output stage control
    input wire logic PAIRED_MODE,
    input wire logic PAIR_EVEN_SLOTS,
    input wire logic [3:0] CH_ENABLE,
    // Received audio and status
    output logic [127:0] CH_DATA,
    output logic FRAME_VALID,
    output logic TDM_ACTIVE,
    output logic CLOCK_ERROR,
    output logic [3:0] CH_HIZ
);

    if (HALT_CYCLES < 64 || HALT_CYCLES > 4096) begin : g_bad_halt
        $error("HALT_CYCLES out of range");
    end

    localparam logic [15:0] HALT_LIMIT = 16'(HALT_CYCLES);

    logic [4:0] raw;
    logic [4:0] s1_reg;
    logic [4:0] s2_reg;
    logic bclk_d_reg;
    logic mclk_d_reg;
    logic [7:0] ctrl_reg;
    logic prev_fs_reg;
    logic edge_d_reg;
    logic half_reg;
    logic [9:0] cnt_reg;
    logic [9:0] fl_cnt_reg;
    logic [9:0] mcnt_reg;
    logic [15:0] idle_reg;
    logic tdm_reg;
    logic err_reg;
    logic fe_d_reg;
    logic [31:0] sh_reg [2];
    logic [31:0] coll_reg [4];

    logic bclk_rise;
    logic mclk_rise;
    logic fs;
    logic [1:0] din;
    logic [5:0] w;
    saip_pkg::saip_fmt_t fmt;
    logic is_i2s;
    logic is_rj;
    logic rise_fs;
    logic fall_fs;
    logic edge_now;
    logic frame_edge;
    logic start;
    logic [9:0] cnt_here;
    logic half_here;
    logic [9:0] k;
    logic slot16;
    logic [2:0] slot;
    logic slot_hi;
    logic [4:0] b;
    logic [1:0] rel;
    logic pair;
    logic left;
    logic [31:0] sh_new [2];
    logic [3:0] hit;
    logic [31:0] val [4];
    logic [9:0] mcnt_here;
    logic len_ok;
    logic tdm_new;
    logic slots_ok;
    logic mclk_ok;
    logic good;
    logic halt;

    function automatic logic [31:0] align(input logic [31:0] v, input logic [5:0] wl);
        case (wl)
            6'h10: return {v[15:0], 16'h0000};
            6'h18: return {v[23:0], 8'h00};
            default: return v;
        endcase
    endfunction

    assign raw = {LINK.serial_data_in_second, LINK.serial_data_in_first, LINK.frame_sync,
                  LINK.bit_clk, LINK.master_clk};

    // Two-stage synchronisers for all link pins
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            s1_reg <= 5'h00;
            s2_reg <= 5'h00;
            bclk_d_reg <= 1'b0;
            mclk_d_reg <= 1'b0;
        end else if (CLK_EN) begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            bclk_d_reg <= s2_reg[saip_pkg::SAIP_SY_BCLK];
            mclk_d_reg <= s2_reg[saip_pkg::SAIP_SY_MCLK];
        end
    end

    // Control register
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ctrl_reg <= saip_pkg::SAIP_CTRL_RESET;
            REG_RDATA <= 8'h00;
        end else if (CLK_EN) begin
            if (REG_WE && REG_ADDR == saip_pkg::SAIP_CTRL_ADDR) begin
                ctrl_reg <= REG_WDATA & saip_pkg::SAIP_CTRL_MASK;
            end
            REG_RDATA <= (REG_ADDR == saip_pkg::SAIP_CTRL_ADDR) ? ctrl_reg : 8'h00;
        end
    end

    always_comb begin
        bclk_rise = s2_reg[saip_pkg::SAIP_SY_BCLK] & ~bclk_d_reg;
        mclk_rise = s2_reg[saip_pkg::SAIP_SY_MCLK] & ~mclk_d_reg;
        fs = s2_reg[saip_pkg::SAIP_SY_FRAME_SYNC];
        din = {s2_reg[saip_pkg::SAIP_SY_DIN2], s2_reg[saip_pkg::SAIP_SY_DIN1]};
        w = saip_pkg::saip_word_bits(ctrl_reg[saip_pkg::SAIP_CTRL_WORD_LSB +: 2]);
        fmt = saip_pkg::saip_fmt_t'(ctrl_reg[saip_pkg::SAIP_CTRL_FMT_LSB +: 2]);
        is_i2s = fmt[1];
        is_rj = (fmt == saip_pkg::SAIP_FMT_RJ);
        rise_fs = fs & ~prev_fs_reg;
        fall_fs = ~fs & prev_fs_reg;
        edge_now = tdm_reg ? rise_fs : (rise_fs | fall_fs);
        frame_edge = (tdm_reg | ~is_i2s) ? rise_fs : fall_fs;
        start = (tdm_reg | is_i2s) ? edge_d_reg : edge_now;
        cnt_here = start ? 10'h001 : ((cnt_reg == 10'h3FF) ? cnt_reg : cnt_reg + 10'h001);
        half_here = start ? fs : half_reg;
        k = cnt_here - 10'h001;
        slot16 = (w == 6'h10);
        slot = slot16 ? k[6:4] : k[7:5];
        slot_hi = slot16 ? (|k[9:7]) : (|k[9:8]);
        b = slot16 ? {1'b0, k[3:0]} : k[4:0];
        rel = slot[1:0];
        pair = rel[1] ^ ctrl_reg[saip_pkg::SAIP_CTRL_SWAP_BIT];
        left = 1'b0;
        sh_new[0] = {sh_reg[0][30:0], din[0]};
        sh_new[1] = {sh_reg[1][30:0], din[1]};
        hit = 4'h0;
        for (int i = 0; i < 4; i++) begin
            val[i] = 32'h0000_0000;
        end
        if (tdm_reg) begin
            // Lane two is ignored in TDM
            if (!slot_hi && {1'b0, b} == w - 6'h01 && slot[2] == ctrl_reg[saip_pkg::SAIP_CTRL_GROUP_BIT]) begin
                if (PAIRED_MODE) begin
                    if (rel[0] == PAIR_EVEN_SLOTS) begin
                        hit[{pair, 1'b0}] = 1'b1;
                        hit[{pair, 1'b1}] = 1'b1;
                        val[{pair, 1'b0}] = align(sh_new[0], w);
                        val[{pair, 1'b1}] = align(sh_new[0], w);
                    end
                end else begin
                    hit[rel ^ {ctrl_reg[saip_pkg::SAIP_CTRL_SWAP_BIT], 1'b0}] = 1'b1;
                    val[rel ^ {ctrl_reg[saip_pkg::SAIP_CTRL_SWAP_BIT], 1'b0}] = align(sh_new[0], w);
                end
            end
        end else if (is_rj) begin
            // Last w bits before the sync change; earlier positions drop out
            if (edge_now) begin
                left = prev_fs_reg;
                hit[{1'b0, ~left}] = 1'b1;
                hit[{1'b1, ~left}] = 1'b1;
                val[{1'b0, ~left}] = align(sh_reg[0], w);
                val[{1'b1, ~left}] = align(sh_reg[1], w);
            end
        end else if (cnt_here == {4'h0, w}) begin
            left = is_i2s ? ~half_here : half_here;
            hit[{1'b0, ~left}] = 1'b1;
            hit[{1'b1, ~left}] = 1'b1;
            val[{1'b0, ~left}] = align(sh_new[0], w);
            val[{1'b1, ~left}] = align(sh_new[1], w);
        end
        mcnt_here = (mclk_rise && mcnt_reg != 10'h3FF) ? mcnt_reg + 10'h001 : mcnt_reg;
        len_ok = (fl_cnt_reg == saip_pkg::SAIP_BCLK_32) || (fl_cnt_reg == saip_pkg::SAIP_BCLK_64) ||
                 (fl_cnt_reg == saip_pkg::SAIP_BCLK_128) || (fl_cnt_reg == saip_pkg::SAIP_BCLK_256);
        tdm_new = (fl_cnt_reg >= saip_pkg::SAIP_BCLK_128);
        slots_ok = ~tdm_new || (fl_cnt_reg == saip_pkg::SAIP_BCLK_128) || ~slot16;
        mclk_ok = (mcnt_here == saip_pkg::SAIP_MCLK_128) || (mcnt_here == saip_pkg::SAIP_MCLK_256) ||
                  (mcnt_here == saip_pkg::SAIP_MCLK_512);
        good = len_ok & slots_ok & mclk_ok;
        halt = (idle_reg == HALT_LIMIT) || (fl_cnt_reg > saip_pkg::SAIP_FRAME_MAX);
    end

    // Bit-clock domain tracking, sampled on each bit clock rise; master clock rises counted every cycle
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            prev_fs_reg <= 1'b0;
            edge_d_reg <= 1'b0;
            half_reg <= 1'b0;
            cnt_reg <= 10'h3FF;
            fl_cnt_reg <= 10'h000;
            mcnt_reg <= 10'h000;
            tdm_reg <= 1'b0;
            sh_reg[0] <= 32'h0000_0000;
            sh_reg[1] <= 32'h0000_0000;
        end else if (CLK_EN) begin
            if (bclk_rise) begin
                prev_fs_reg <= fs;
                edge_d_reg <= edge_now;
                half_reg <= half_here;
                cnt_reg <= cnt_here;
                sh_reg[0] <= sh_new[0];
                sh_reg[1] <= sh_new[1];
                if (frame_edge) begin
                    fl_cnt_reg <= 10'h001;
                    mcnt_reg <= 10'h000;
                    if (len_ok) begin
                        tdm_reg <= tdm_new;
                    end
                end else begin
                    fl_cnt_reg <= (fl_cnt_reg == 10'h3FF) ? fl_cnt_reg : fl_cnt_reg + 10'h001;
                    mcnt_reg <= mcnt_here;
                end
            end else begin
                mcnt_reg <= mcnt_here;
            end
        end
    end

    // Clock fault detection with automatic recovery
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            idle_reg <= 16'h0000;
            err_reg <= 1'b1;
        end else if (CLK_EN) begin
            if (bclk_rise) begin
                idle_reg <= 16'h0000;
            end else if (idle_reg != HALT_LIMIT) begin
                idle_reg <= idle_reg + 16'h0001;
            end
            if (halt) begin
                err_reg <= 1'b1;
            end else if (bclk_rise && frame_edge) begin
                err_reg <= ~good;
            end
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_chan
        always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
                coll_reg[g] <= 32'h0000_0000;
                CH_DATA[g*32 +: 32] <= 32'h0000_0000;
            end else if (CLK_EN) begin
                if (bclk_rise && hit[g]) begin
                    coll_reg[g] <= val[g];
                end
                if (fe_d_reg && !err_reg) begin
                    CH_DATA[g*32 +: 32] <= coll_reg[g];
                end
            end
        end
    end

    // Publish once per frame, one cycle after the frame edge
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            fe_d_reg <= 1'b0;
            FRAME_VALID <= 1'b0;
            CH_HIZ <= 4'hF;
        end else if (CLK_EN) begin
            fe_d_reg <= bclk_rise & frame_edge;
            FRAME_VALID <= fe_d_reg & ~err_reg;
            CH_HIZ <= err_reg ? 4'hF : ~CH_ENABLE;
        end
    end

    assign TDM_ACTIVE = tdm_reg;
    assign CLOCK_ERROR = err_reg;

endmodule // saip_device
`default_nettype wire

// ### core/saip_host.sv
`timescale 1ns/1ps
`default_nettype none
module saip_host #(
    parameter int MCLK_HALF = saip_pkg::SAIP_MCLK_HALF_MIN
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Serial audio link
    saip_link_if.host LINK
);

    if (MCLK_HALF < saip_pkg::SAIP_MCLK_HALF_MIN || MCLK_HALF > 255) begin : g_bad_half
        $error("MCLK_HALF below audio clock limit or too large");
    end

    localparam logic [15:0] MH = 16'(MCLK_HALF);

    logic [31:0] ctrl_reg;
    logic [31:0] data_reg [8];
    logic [15:0] frame_cnt_reg;
    logic [15:0] mdiv_reg;
    logic [15:0] bdiv_reg;
    logic [9:0] p_reg;
    logic mclk_reg;
    logic bclk_reg;
    logic fs_reg;
    logic d1_reg;
    logic d2_reg;

    logic en;
    logic data_page;
    logic mapped;
    logic [1:0] fsel;
    logic [9:0] fb;
    logic [9:0] half;
    logic [15:0] bhalf;
    logic [9:0] q;
    logic [9:0] qq;
    logic [9:0] j;
    logic h;
    logic fs_n;
    logic bit_ok;
    logic chsel;
    logic [2:0] slot;
    logic [5:0] w;
    logic [5:0] pos;
    logic [31:0] src1;
    logic [31:0] src2;
    saip_pkg::saip_fmt_t fmt;

    assign en = ctrl_reg[saip_pkg::SAIP_H_EN_BIT];
    assign data_page = (PADDR[11:5] == saip_pkg::SAIP_H_DATA_PAGE) && (PADDR[1:0] == 2'b00);
    assign mapped = (PADDR == saip_pkg::SAIP_H_CTRL) || (PADDR == saip_pkg::SAIP_H_STATUS) || data_page;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;

    // Register writes and read data staging
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ctrl_reg <= saip_pkg::SAIP_H_CTRL_RESET;
            PRDATA <= 32'h0000_0000;
            for (int i = 0; i < 8; i++) begin
                data_reg[i] <= 32'h0000_0000;
            end
        end else if (CLK_EN) begin
            if (PSEL && PENABLE && PWRITE) begin
                if (PADDR == saip_pkg::SAIP_H_CTRL) begin
                    ctrl_reg <= PWDATA;
                end else if (data_page) begin
                    data_reg[PADDR[4:2]] <= PWDATA;
                end
            end
            if (PSEL && !PENABLE) begin
                if (PADDR == saip_pkg::SAIP_H_CTRL) begin
                    PRDATA <= ctrl_reg;
                end else if (PADDR == saip_pkg::SAIP_H_STATUS) begin
                    PRDATA <= {15'h0000, en, frame_cnt_reg};
                end else if (data_page) begin
                    PRDATA <= data_reg[PADDR[4:2]];
                end else begin
                    PRDATA <= 32'h0000_0000;
                end
            end
        end
    end

    // Next bit position and the level for each line there
    always_comb begin
        fsel = ctrl_reg[saip_pkg::SAIP_H_FSEL_LSB +: 2];
        fb = saip_pkg::SAIP_BCLK_32 << fsel;
        half = fb >> 1;
        bhalf = MH << (2'h3 - fsel);
        w = saip_pkg::saip_word_bits(ctrl_reg[saip_pkg::SAIP_H_WORD_LSB +: 2]);
        fmt = saip_pkg::saip_fmt_t'(ctrl_reg[saip_pkg::SAIP_H_FMT_LSB +: 2]);
        q = (p_reg >= fb - 10'h001) ? 10'h000 : p_reg + 10'h001;
        h = (q >= half);
        qq = h ? q - half : q;
        slot = 3'h0;
        chsel = h;
        src1 = 32'h0000_0000;
        src2 = 32'h0000_0000;
        if (ctrl_reg[saip_pkg::SAIP_H_TDM_BIT]) begin
            fs_n = (q < saip_pkg::SAIP_TDM_SYNC_BITS);
            j = (q == 10'h000) ? fb - 10'h001 : q - 10'h001;
            if (w == 6'h10) begin
                slot = j[6:4];
                bit_ok = ~(|j[9:7]) && ({2'b00, j[3:0]} < w);
                pos = w - 6'h01 - {2'b00, j[3:0]};
            end else begin
                slot = j[7:5];
                bit_ok = ~(|j[9:8]) && ({1'b0, j[4:0]} < w);
                pos = w - 6'h01 - {1'b0, j[4:0]};
            end
            src1 = data_reg[slot];
        end else begin
            if (fmt[1]) begin
                fs_n = h;
                j = (qq == 10'h000) ? half - 10'h001 : qq - 10'h001;
                chsel = (qq == 10'h000) ? ~h : h;
            end else if (fmt == saip_pkg::SAIP_FMT_RJ) begin
                fs_n = ~h;
                j = qq + {4'h0, w} - half;
            end else begin
                fs_n = ~h;
                j = qq;
            end
            if (fmt == saip_pkg::SAIP_FMT_RJ) begin
                bit_ok = (qq + {4'h0, w} >= half) && (j < {4'h0, w});
            end else begin
                bit_ok = (j < {4'h0, w});
            end
            pos = w - 6'h01 - j[5:0];
            src1 = data_reg[{2'b00, chsel}];
            src2 = data_reg[{2'b01, chsel}];
        end
    end

    // Clock dividers and bit output on the bit clock falling edge
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            mdiv_reg <= 16'h0000;
            bdiv_reg <= 16'h0000;
            mclk_reg <= 1'b0;
            bclk_reg <= 1'b0;
            p_reg <= 10'h3FF;
            fs_reg <= 1'b0;
            d1_reg <= 1'b0;
            d2_reg <= 1'b0;
            frame_cnt_reg <= 16'h0000;
        end else if (CLK_EN) begin
            if (!en) begin
                mdiv_reg <= 16'h0000;
                bdiv_reg <= 16'h0000;
                mclk_reg <= 1'b0;
                bclk_reg <= 1'b0;
                p_reg <= 10'h3FF;
                fs_reg <= 1'b0;
                d1_reg <= 1'b0;
                d2_reg <= 1'b0;
            end else begin
                if (mdiv_reg >= MH - 16'h0001) begin
                    mdiv_reg <= 16'h0000;
                    mclk_reg <= ~mclk_reg;
                end else begin
                    mdiv_reg <= mdiv_reg + 16'h0001;
                end
                if (bdiv_reg >= bhalf - 16'h0001) begin
                    bdiv_reg <= 16'h0000;
                    bclk_reg <= ~bclk_reg;
                    if (bclk_reg) begin
                        p_reg <= q;
                        fs_reg <= fs_n;
                        d1_reg <= bit_ok & src1[pos[4:0]];
                        d2_reg <= bit_ok & src2[pos[4:0]];
                        if (q == 10'h000) begin
                            frame_cnt_reg <= frame_cnt_reg + 16'h0001;
                        end
                    end
                end else begin
                    bdiv_reg <= bdiv_reg + 16'h0001;
                end
            end
        end
    end

    assign LINK.master_clk = mclk_reg;
    assign LINK.bit_clk = bclk_reg;
    assign LINK.frame_sync = fs_reg;
    assign LINK.serial_data_in_first = d1_reg;
    assign LINK.serial_data_in_second = d2_reg;

endmodule // saip_host
`default_nettype wire

// ### core/saip_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### testbench/saip_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module saip_link_monitor (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Link wires
    input wire logic master_clk,
    input wire logic bit_clk,
    input wire logic frame_sync,
    input wire logic serial_data_in_first,
    // Device status
    input wire logic [3:0] CH_ENABLE,
    input wire logic [3:0] CH_HIZ,
    input wire logic CLOCK_ERROR,
    input wire logic FRAME_VALID,
    input wire logic TDM_ACTIVE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_half; frame_sync[*8]; endsequence
    sequence s_tdm_sync; s_half ##1 frame_sync[*7]; endsequence
    a_sync_clk_low: assert property ($changed(frame_sync) |-> !bit_clk) else $error("sync moved");
    a_data_clk_low: assert property ($changed(serial_data_in_first) |-> !bit_clk) else $error("data moved");
    // Checked on the low phase: a host stop may legally cut a high phase short
    a_bclk_low_min: assert property ($rose(bit_clk) |-> !$past(bit_clk, 2) && !$past(bit_clk, 3)
        && !$past(bit_clk, 4)) else $error("bit clock too fast");
    a_mclk_low_min: assert property ($fell(master_clk) |=> !master_clk[*3]) else $error("master clock fast");
    a_tdm_sync_len: assert property (TDM_ACTIVE && $rose(frame_sync) |=> s_tdm_sync) else $error("sync short");
    a_hiz_on_err: assert property (CLOCK_ERROR && $past(CLOCK_ERROR) |-> CH_HIZ == 4'hF) else $error("not hiz");
    a_hiz_resume: assert property (!CLOCK_ERROR && !$past(CLOCK_ERROR) && $stable(CH_ENABLE)
        |-> CH_HIZ == ~CH_ENABLE) else $error("no resume");
    a_valid_no_err: assert property (FRAME_VALID |-> !CLOCK_ERROR) else $error("publish in error");
    a_valid_single: assert property (FRAME_VALID |=> !FRAME_VALID[*8]) else $error("valid too long");
endmodule // saip_link_monitor
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, se, reg_we, fv, tdm, cerr, pm, pe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, hc;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, dc;
    logic [3:0] ch_en, hiz;
    logic [127:0] ch_data;
    logic [31:0] dat [8];
    logic [31:0] hcfg [4] = '{32'h45, 32'h0D, 32'h41, 32'h43};
    logic [7:0] dcfg [4] = '{8'h04, 8'h44, 8'h00, 8'h02};
    int n_fail, checks, cyc = 0, seed, i, c, g, s;
    saip_link_if saip_link_if_inst ();
    saip_host #(.MCLK_HALF(4)) saip_host_inst (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .LINK(saip_link_if_inst.host));
    saip_device #(.HALT_CYCLES(256)) saip_device_inst (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1),
        .LINK(saip_link_if_inst.device), .REG_WE(reg_we), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .PAIRED_MODE(pm), .PAIR_EVEN_SLOTS(pe), .CH_ENABLE(ch_en), .CH_DATA(ch_data),
        .FRAME_VALID(fv), .TDM_ACTIVE(tdm), .CLOCK_ERROR(cerr), .CH_HIZ(hiz));
    saip_link_monitor saip_link_monitor_inst (.CORE_CLK(clk), .RST_N(rst_n),
        .master_clk(saip_link_if_inst.master_clk), .bit_clk(saip_link_if_inst.bit_clk),
        .frame_sync(saip_link_if_inst.frame_sync), .serial_data_in_first(saip_link_if_inst.serial_data_in_first),
        .CH_ENABLE(ch_en), .CH_HIZ(hiz), .CLOCK_ERROR(cerr), .FRAME_VALID(fv), .TDM_ACTIVE(tdm));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 98000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, entered and left just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic dev_wr(input logic [7:0] d);
        reg_we <= 1'b1;
        reg_wdata <= d;
        @(posedge clk) reg_we <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk({24'h0, reg_rdata}, {24'h0, d & 8'hEE});
        @(posedge clk);
    endtask
    function automatic logic [31:0] exp_ch(int c, int i, int g, int s);
        // Paired runs: pair takes the odd or even slot of its half group
        if (i >= 8) return dat[4 * g + 2 * ((c >> 1) ^ s) + ((i == 8) ? 1 : 0)];
        if (i >= 4) return dat[4 * g + (c ^ (2 * s))];
        return dat[c] << ((i == 1) ? 16 : 8);
    endfunction
    initial begin
        seed = 86189;
        {psel, penable, pwrite, reg_we, rst_n, pm, pe, n_fail, checks} = '0;
        paddr = '0;
        pwdata = '0;
        reg_addr = 8'h03;
        reg_wdata = '0;
        ch_en = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk({24'h0, reg_rdata}, 32'h04);
        @(posedge clk);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h4);
        apb(1'b1, 12'h100, 32'h1);
        chk({31'h0, se}, 32'h1);
        dev_wr(8'hFF);
        for (i = 0; i < 10; i++) begin
            g = (i < 8) ? (i >> 1) & 1 : i & 1;
            s = i & 1;
            if (i == 4) begin
                // Stopping the host halts every clock
                apb(1'b1, 12'h000, 32'h0);
                repeat (600) @(posedge clk);
                @(negedge clk);
                chk({31'h0, cerr}, 32'h1);
                chk({28'h0, hiz}, 32'hF);
                @(posedge clk);
            end
            for (c = 0; c < 8; c++) begin
                dat[c] = $random(seed);
                apb(1'b1, 12'h020 + 12'(c * 4), dat[c]);
            end
            ch_en <= 4'($random(seed));
            pm <= (i >= 8);
            pe <= (i == 8);
            hc = (i < 4) ? hcfg[i] : 32'hF1;
            dc = (i < 4) ? dcfg[i] : 8'(8'h80 | (g << 5) | (s << 3));
            apb(1'b1, 12'h000, hc);
            dev_wr(dc);
            repeat (3) begin
                @(negedge clk);
                while (fv !== 1'b1) @(negedge clk);
            end
            for (c = 0; c < 4; c++) chk(ch_data[c * 32 +: 32], exp_ch(c, i, g, s));
            chk({28'h0, hiz}, {28'h0, ~ch_en});
            chk({31'h0, tdm}, (i >= 4) ? 32'h1 : 32'h0);
            @(posedge clk);
        end
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
